// *** design/ahsp_cfg.svh ***
// Named constants of the host serial port: addresses, offsets, reset values, timings.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AHSP_CFG_SVH
`define AHSP_CFG_SVH

// Core clock rate in MHz
`define AHSP_CLK_MHZ       40
// Bus watchdog periods in microseconds (short and long selection)
`define AHSP_WDT_SHORT_US  1000
`define AHSP_WDT_LONG_US   50000
// Width of the watchdog counter, enough for the long period
`define AHSP_WDT_W         22
// Slave addresses for strap high and strap low
`define AHSP_ADDR_STRAP_HI 7'h1F
`define AHSP_ADDR_STRAP_LO 7'h0F
// Interface configuration register offset and reset value
`define AHSP_REG_CFG       8'h34
`define AHSP_CFG_RST       8'h00
// Positions of the synchronised pins in the pin vector
`define AHSP_PIN_CS        0
`define AHSP_PIN_SCK       1
`define AHSP_PIN_SDA       2
`define AHSP_PIN_STRAP     3
// Idle level of all synchronised pins (pulled high)
`define AHSP_PIN_RST       4'hF
// Bits in one byte on the I2C side, last bit index on the SPI side
`define AHSP_BYTE_BITS     4'h8
`define AHSP_SPI_LAST      3'h7
// Read flag position in the SPI command byte
`define AHSP_SPI_RD_BIT    7
// Number of register bytes held in the register memory
`define AHSP_REG_DEPTH     256

`endif

// *** design/ahsp_pkg.sv ***
// Types shared by the host serial port and its register memory.
// Assumes the constants header sits beside it.
`include "ahsp_cfg.svh"

package ahsp_pkg;

	// I2C slave sequencer states, one-hot
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_ACKA = 7'h04,
		I2C_WR   = 7'h08,
		I2C_ACKW = 7'h10,
		I2C_RD   = 7'h20,
		I2C_MACK = 7'h40
	} ahsp_i2c_e;

	// Interface configuration register layout
	typedef struct packed {
		logic [4:0] rsvd;        // Stored, no effect
		logic       wdt_en;      // Bus watchdog enable
		logic       wdt_sel;     // Bus watchdog period select
		logic       three_wire;  // SPI three-wire select
	} ahsp_cfg_s;

	// One register write toward the register memory
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} ahsp_wr_s;

endpackage : ahsp_pkg

// *** design/ahsp_regmem.sv ***
// Register byte memory behind the host serial port.
// Assumes one writer per cycle; read data come from a register one clock after the address.
`timescale 1ns/1ps
`include "ahsp_cfg.svh"

module ahsp_regmem #(
	parameter int unsigned DEPTH = `AHSP_REG_DEPTH
) (
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	input  wire ahsp_pkg::ahsp_wr_s wr_in,
	input  wire logic [7:0]        rd_addr_in,
	output logic      [7:0]        rd_data_out
);
	import ahsp_pkg::*;

	// Storage array, no reset: contents belong to the rest of the device
	logic [7:0] mem_ff [DEPTH];

	// Write port
	always_ff @(posedge clk_in) begin
		if (wr_in.en) begin
			mem_ff[wr_in.addr] <= wr_in.data;
		end
	end

	// Registered read port, always enabled
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_data_out <= 8'h00;
		end else begin
			rd_data_out <= mem_ff[rd_addr_in];
		end
	end

endmodule : ahsp_regmem

// *** design/ahsp_port.sv ***
// Host serial port: I2C or SPI slave giving the host access to every register byte over I2C, the lower 128 over SPI.
// Assumes all pins arrive asynchronously and that the host is always the bus master.
`timescale 1ns/1ps
`include "ahsp_cfg.svh"

module ahsp_port #(
	parameter int unsigned WDT_SHORT_CYC = `AHSP_WDT_SHORT_US * `AHSP_CLK_MHZ,
	parameter int unsigned WDT_LONG_CYC  = `AHSP_WDT_LONG_US * `AHSP_CLK_MHZ
) (
	input  wire logic                clk_in,
	input  wire logic                resetn_in,
	input  wire logic                cs_n_pin_in,
	input  wire logic                sclk_pin_in,
	input  wire logic                sda_pin_in,
	output logic                     sda_pin_out,
	output logic                     sda_pin_oe_n_out,
	input  wire logic                slave_addr_bit_pin_in,
	output logic                     slave_addr_bit_pin_out,
	output logic                     slave_addr_bit_pin_oe_n_out,
	output logic                     spi_mode_out,
	output ahsp_pkg::ahsp_cfg_s      interface_config_out
);
	import ahsp_pkg::*;

	// Offset decode, used by the config write and the read mux
	function automatic logic is_cfg(input logic [7:0] addr);
		is_cfg = (addr == `AHSP_REG_CFG);
	endfunction : is_cfg

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and filter
	logic [3:0] pin_raw;          // Raw pins in vector order
	logic [3:0] sync1_ff;         // First stage, read only by second
	logic [3:0] sync2_ff;         // Second stage
	logic [3:0] sync3_ff;         // Third stage
	logic [3:0] filt_ff;          // Accepted level
	logic [3:0] filt_d_ff;        // Accepted level one clock ago

	assign pin_raw[`AHSP_PIN_CS]    = cs_n_pin_in;
	assign pin_raw[`AHSP_PIN_SCK]   = sclk_pin_in;
	assign pin_raw[`AHSP_PIN_SDA]   = sda_pin_in;
	assign pin_raw[`AHSP_PIN_STRAP] = slave_addr_bit_pin_in;

	// A change counts once stages two and three agree; rejects one-sample glitches
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_ff  <= `AHSP_PIN_RST;
			sync2_ff  <= `AHSP_PIN_RST;
			sync3_ff  <= `AHSP_PIN_RST;
			filt_ff   <= `AHSP_PIN_RST;
			filt_d_ff <= `AHSP_PIN_RST;
		end else begin
			sync1_ff  <= pin_raw;
			sync2_ff  <= sync1_ff;
			sync3_ff  <= sync2_ff;
			filt_ff   <= ((sync2_ff ~^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & filt_ff);
			filt_d_ff <= filt_ff;
		end
	end

	// Edge and condition decode
	logic cs_n, scl, sda, scl_d, sda_d;
	logic scl_rise, scl_fall, cs_fall, i2c_start, i2c_stop;
	assign cs_n      = filt_ff[`AHSP_PIN_CS];
	assign scl       = filt_ff[`AHSP_PIN_SCK];
	assign sda       = filt_ff[`AHSP_PIN_SDA];
	assign scl_d     = filt_d_ff[`AHSP_PIN_SCK];
	assign sda_d     = filt_d_ff[`AHSP_PIN_SDA];
	assign scl_rise  = scl & ~scl_d;
	assign scl_fall  = ~scl & scl_d;
	assign cs_fall   = ~cs_n & filt_d_ff[`AHSP_PIN_CS];
	assign i2c_start = scl & scl_d & ~sda & sda_d;
	assign i2c_stop  = scl & scl_d & sda & ~sda_d;

	////////////////////////////////////////////////////////////////////////////////
	// Interface selection
	logic spi_mode_ff;            // Sticky once select seen low

	// SPI toggles select between frames, so SPI is kept once chosen
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spi_mode_ff <= 1'b0;
		end else if (!cs_n) begin
			spi_mode_ff <= 1'b1;
		end
	end

	logic i2c_en, spi_act;
	assign i2c_en  = ~spi_mode_ff;
	assign spi_act = spi_mode_ff & ~cs_n;

	////////////////////////////////////////////////////////////////////////////////
	// Shared register pointer, config register and memory
	ahsp_cfg_s  cfg_ff;           // Interface configuration
	logic [7:0] ptr_ff;           // Register pointer
	logic [7:0] mem_rdata;        // Registered memory read data
	logic [7:0] rd_byte;          // Byte at the pointer
	ahsp_wr_s   wr;               // Write toward memory and config
	logic       i2c_ptr_load, i2c_mem_wr, i2c_load;
	logic       spi_ptr_load, spi_mem_wr, spi_load;
	logic [7:0] i2c_sh_ff;        // I2C receive shifter
	logic [7:0] spi_byte;         // SPI byte including the bit in flight

	assign rd_byte  = is_cfg(ptr_ff) ? cfg_ff : mem_rdata;
	assign wr.en    = i2c_mem_wr | spi_mem_wr;
	assign wr.addr  = ptr_ff;
	assign wr.data  = i2c_mem_wr ? i2c_sh_ff : spi_byte;

	// Pointer: loaded by the address byte, advanced after each byte written and as each read byte is loaded
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ptr_ff <= 8'h00;
		end else if (i2c_ptr_load) begin
			ptr_ff <= i2c_sh_ff;
		end else if (spi_ptr_load) begin
			ptr_ff <= {1'b0, spi_byte[6:0]};
		end else if (wr.en || i2c_load || spi_load) begin
			ptr_ff <= ptr_ff + 8'h01;
		end
	end

	// Config register steers the watchdog and the SPI wiring
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_ff <= `AHSP_CFG_RST;
		end else if (wr.en && is_cfg(wr.addr)) begin
			cfg_ff <= wr.data;
		end
	end

	ahsp_regmem #(
		.DEPTH (`AHSP_REG_DEPTH)
	) u_regmem (
		.clk_in      (clk_in),
		.resetn_in   (resetn_in),
		.wr_in       (wr),
		.rd_addr_in  (ptr_ff),
		.rd_data_out (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// I2C slave sequencer
	ahsp_i2c_e  i2c_st_ff;        // Sequencer state
	logic [3:0] i2c_cnt_ff;       // Bit count within byte
	logic [7:0] i2c_tx_ff;        // Transmit shifter
	logic       i2c_rw_ff;        // Read requested
	logic       i2c_ptr_ph_ff;    // Next write byte is the pointer
	logic       i2c_pull_ff;      // Pull SDA low
	logic       i2c_ack_ff;       // Host acked last read byte
	logic [6:0] own_addr;
	logic [`AHSP_WDT_W-1:0] wdt_cnt_ff;
	logic [`AHSP_WDT_W-1:0] wdt_lim;
	logic       wdt_expire;

	// Strap only read in I2C mode; in four-wire SPI it is our output
	assign own_addr = filt_ff[`AHSP_PIN_STRAP] ? `AHSP_ADDR_STRAP_HI : `AHSP_ADDR_STRAP_LO;
	assign i2c_ptr_load = i2c_en & (i2c_st_ff == I2C_WR) & scl_fall
		& (i2c_cnt_ff == `AHSP_BYTE_BITS) & i2c_ptr_ph_ff;
	assign i2c_mem_wr = i2c_en & (i2c_st_ff == I2C_WR) & scl_fall
		& (i2c_cnt_ff == `AHSP_BYTE_BITS) & ~i2c_ptr_ph_ff;
	assign i2c_load = i2c_en & scl_fall & ~wdt_expire & ~i2c_start & ~i2c_stop
		& (((i2c_st_ff == I2C_ACKA) & i2c_rw_ff) | ((i2c_st_ff == I2C_MACK) & i2c_ack_ff));

	// Sequencer; only ever answers, never opens a transfer
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			i2c_st_ff     <= I2C_IDLE;
			i2c_cnt_ff    <= 4'h0;
			i2c_sh_ff     <= 8'h00;
			i2c_tx_ff     <= 8'h00;
			i2c_rw_ff     <= 1'b0;
			i2c_ptr_ph_ff <= 1'b0;
			i2c_pull_ff   <= 1'b0;
			i2c_ack_ff    <= 1'b0;
		end else if (!i2c_en || wdt_expire || i2c_stop) begin
			i2c_st_ff   <= I2C_IDLE;
			i2c_pull_ff <= 1'b0;
		end else if (i2c_start) begin
			i2c_st_ff   <= I2C_ADDR;
			i2c_cnt_ff  <= 4'h0;
			i2c_pull_ff <= 1'b0;
		end else begin
			case (i2c_st_ff)
				I2C_ADDR, I2C_WR: begin
					if (scl_rise && i2c_cnt_ff != `AHSP_BYTE_BITS) begin
						i2c_sh_ff  <= {i2c_sh_ff[6:0], sda};
						i2c_cnt_ff <= i2c_cnt_ff + 4'h1;
					end else if (scl_fall && i2c_cnt_ff == `AHSP_BYTE_BITS) begin
						if (i2c_st_ff == I2C_WR) begin
							i2c_pull_ff   <= 1'b1;
							i2c_ptr_ph_ff <= 1'b0;
							i2c_st_ff     <= I2C_ACKW;
						end else if (i2c_sh_ff[7:1] == own_addr) begin
							i2c_rw_ff     <= i2c_sh_ff[0];
							i2c_ptr_ph_ff <= ~i2c_sh_ff[0];
							i2c_pull_ff   <= 1'b1;
							i2c_st_ff     <= I2C_ACKA;
						end else begin
							i2c_st_ff <= I2C_IDLE;  // Not our address
						end
					end
				end
				I2C_ACKW: begin
					if (scl_fall) begin
						i2c_pull_ff <= 1'b0;
						i2c_cnt_ff  <= 4'h0;
						i2c_st_ff   <= I2C_WR;
					end
				end
				I2C_ACKA, I2C_MACK: begin
					if (scl_rise && i2c_st_ff == I2C_MACK) begin
						i2c_ack_ff <= ~sda;
					end else if (i2c_load) begin
						i2c_pull_ff <= ~rd_byte[7];
						i2c_tx_ff   <= {rd_byte[6:0], 1'b0};
						i2c_cnt_ff  <= 4'h1;
						i2c_st_ff   <= I2C_RD;
					end else if (scl_fall) begin
						i2c_pull_ff <= 1'b0;
						i2c_cnt_ff  <= 4'h0;
						i2c_st_ff   <= (i2c_st_ff == I2C_ACKA) ? I2C_WR : I2C_IDLE;
					end
				end
				I2C_RD: begin
					if (scl_fall && i2c_cnt_ff == `AHSP_BYTE_BITS) begin
						i2c_pull_ff <= 1'b0;  // Release for host ack
						i2c_st_ff   <= I2C_MACK;
					end else if (scl_fall) begin
						i2c_pull_ff <= ~i2c_tx_ff[7];
						i2c_tx_ff   <= {i2c_tx_ff[6:0], 1'b0};
						i2c_cnt_ff  <= i2c_cnt_ff + 4'h1;
					end
				end
				default: begin
					i2c_st_ff <= I2C_IDLE;
				end
			endcase
		end
	end

	// Watchdog: cycles since last SCL edge while a transfer is open
	assign wdt_lim    = cfg_ff.wdt_sel ? `AHSP_WDT_W'(WDT_LONG_CYC) : `AHSP_WDT_W'(WDT_SHORT_CYC);
	assign wdt_expire = cfg_ff.wdt_en & (wdt_cnt_ff >= wdt_lim);
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wdt_cnt_ff <= '0;
		end else if (i2c_st_ff == I2C_IDLE || scl_rise || scl_fall) begin
			wdt_cnt_ff <= '0;
		end else if (!wdt_expire) begin
			wdt_cnt_ff <= wdt_cnt_ff + `AHSP_WDT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// SPI slave, modes 0 and 3; sample on rising SCK, shift out on falling
	logic       spi_mode3_ff;     // SCK was high at select fall
	logic [2:0] spi_cnt_ff;       // Bit count within byte
	logic [7:0] spi_sh_ff;        // Receive shifter
	logic [7:0] spi_tx_ff;        // Transmit shifter
	logic       spi_cmd_ff;       // Next byte is the command
	logic       spi_rw_ff;        // Read transfer
	logic       spi_started_ff;   // A rising edge was seen
	logic       spi_drive_ff;     // Output active
	logic       spi_bit_ff;       // Current output bit
	logic       spi_fall_ok;
	logic       spi_rbyte;

	// Mode 3 opens with a falling edge that carries no data
	assign spi_fall_ok  = ~(spi_mode3_ff & ~spi_started_ff);
	assign spi_byte     = {spi_sh_ff[6:0], sda};
	assign spi_rbyte    = spi_act & ~cs_fall & scl_rise & (spi_cnt_ff == `AHSP_SPI_LAST);
	assign spi_ptr_load = spi_rbyte & spi_cmd_ff;
	assign spi_mem_wr   = spi_rbyte & ~spi_cmd_ff & ~spi_rw_ff;
	assign spi_load     = spi_act & ~cs_fall & scl_fall & spi_fall_ok & ~spi_cmd_ff
		& spi_rw_ff & (spi_cnt_ff == 3'h0);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			spi_mode3_ff   <= 1'b0;
			spi_cnt_ff     <= 3'h0;
			spi_sh_ff      <= 8'h00;
			spi_tx_ff      <= 8'h00;
			spi_cmd_ff     <= 1'b1;
			spi_rw_ff      <= 1'b0;
			spi_started_ff <= 1'b0;
			spi_drive_ff   <= 1'b0;
			spi_bit_ff     <= 1'b0;
		end else if (cs_fall) begin
			spi_mode3_ff   <= scl;
			spi_cnt_ff     <= 3'h0;
			spi_cmd_ff     <= 1'b1;
			spi_started_ff <= 1'b0;
			spi_drive_ff   <= 1'b0;
		end else if (!spi_act) begin
			spi_drive_ff <= 1'b0;  // Frame over
		end else if (scl_rise) begin
			spi_sh_ff      <= spi_byte;
			spi_cnt_ff     <= spi_cnt_ff + 3'h1;
			spi_started_ff <= 1'b1;
			if (spi_ptr_load) begin
				spi_rw_ff  <= spi_byte[`AHSP_SPI_RD_BIT];
				spi_cmd_ff <= 1'b0;
			end
		end else if (spi_load) begin
			spi_bit_ff   <= rd_byte[7];
			spi_tx_ff    <= {rd_byte[6:0], 1'b0};
			spi_drive_ff <= 1'b1;
		end else if (scl_fall && spi_fall_ok && spi_drive_ff) begin
			spi_bit_ff <= spi_tx_ff[7];
			spi_tx_ff  <= {spi_tx_ff[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered; enables are low while driving
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sda_pin_out                 <= 1'b0;
			sda_pin_oe_n_out            <= 1'b1;
			slave_addr_bit_pin_out      <= 1'b0;
			slave_addr_bit_pin_oe_n_out <= 1'b1;
		end else begin
			// Open drain in I2C: level stays low, only the enable moves
			sda_pin_out      <= spi_mode_ff & spi_bit_ff;
			sda_pin_oe_n_out <= spi_mode_ff ? ~(cfg_ff.three_wire & spi_drive_ff & spi_act)
				: ~i2c_pull_ff;
			slave_addr_bit_pin_out      <= spi_bit_ff;
			slave_addr_bit_pin_oe_n_out <= ~(spi_mode_ff & ~cfg_ff.three_wire
				& spi_drive_ff & spi_act);
		end
	end

	assign spi_mode_out         = spi_mode_ff;
	assign interface_config_out = cfg_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_addr_done;
		(i2c_st_ff == I2C_ADDR) && scl_fall && (i2c_cnt_ff == `AHSP_BYTE_BITS) && i2c_en
			&& !wdt_expire && !i2c_start && !i2c_stop;
	endsequence
	property p_mode_sel;
		!cs_n |=> spi_mode_ff;
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("select low not giving SPI");
	property p_addr_ack;
		s_addr_done ##0 (i2c_sh_ff[7:1] == own_addr) |=> i2c_pull_ff ##1 !sda_pin_oe_n_out;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
	// Address not matching the strap level must be left alone, no ACK pulled
	property p_addr_map;
		s_addr_done ##0 (i2c_sh_ff[7:1] != (filt_ff[`AHSP_PIN_STRAP] ? `AHSP_ADDR_STRAP_HI
			: `AHSP_ADDR_STRAP_LO)) |=> (i2c_st_ff == I2C_IDLE) && !i2c_pull_ff;
	endproperty
	a_addr_map: assert property (p_addr_map) else $error("foreign address not refused");
	property p_wdt;
		wdt_expire && i2c_en |=> (i2c_st_ff == I2C_IDLE) ##1 sda_pin_oe_n_out;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog did not free bus");
	property p_cfg_wr;
		wr.en && is_cfg(wr.addr) |=> cfg_ff == $past(wr.data);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");
	property p_mode3;
		cs_fall |=> spi_mode3_ff == $past(scl);
	endproperty
	a_mode3: assert property (p_mode3) else $error("SPI mode not sampled");
	property p_three_wire;
		spi_drive_ff && spi_act && cfg_ff.three_wire |=> slave_addr_bit_pin_oe_n_out;
	endproperty
	a_three_wire: assert property (p_three_wire) else $error("SDO driven in 3-wire");
	property p_open_drain;
		!spi_mode_ff |=> !sda_pin_out && slave_addr_bit_pin_oe_n_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("I2C pins driven high");
	property p_idle_quiet;
		(i2c_st_ff == I2C_IDLE) && !spi_mode_ff |=> ##1 sda_pin_oe_n_out;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drove SDA while idle");
	property p_seq_rd;
		i2c_load || spi_load |=> ptr_ff == $past(ptr_ff) + 8'h01;
	endproperty
	a_seq_rd: assert property (p_seq_rd) else $error("pointer not advanced");

endmodule : ahsp_port

// *** dv/ahsp_host_model.sv ***
// Host bus master model: drives I2C or SPI traffic toward the serial port.
// Assumes the bench resolves the shared wires and feeds them back here.
`timescale 1ns/1ps

module ahsp_host_model (
	input  wire logic clk_in,    // Core clock, paces every level
	input  wire logic sda_in,    // Resolved data wire
	input  wire logic strap_in,  // Resolved strap / serial out wire
	output logic      cs_n_out,  // Select, high keeps I2C
	output logic      sclk_out,  // SCL or SCK
	output logic      sda_out    // Data, 1 releases the line
);

	// Idle bus at time zero
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
		sda_out  = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Core clock counting
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt

	////////////////////////////////////////////////////////////////////////////
	// I2C, host always opens the cycle
	// Levels of 5 clocks keep SDA clear of the device's output latency
	task automatic i2c_bit(input logic b, output logic r);
		wt(5);
		sda_out <= b;
		wt(5);
		sclk_out <= 1'b1;
		wt(5);
		r = sda_in;
		sclk_out <= 1'b0;
	endtask : i2c_bit

	// Eight bits then the acknowledge slot, MSB first
	task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
		int i;
		for (i = 8; i >= 0; i--) begin
			i2c_bit(tx[i], rx[i]);
		end
	endtask : i2c_byte

	// Start, also serves as repeated start
	// Waits out the device's ACK release before SDA goes high, else a false stop
	task automatic i2c_start();
		wt(5);
		sda_out <= 1'b1;
		wt(5);
		sclk_out <= 1'b1;
		wt(5);
		sda_out <= 1'b0;
		wt(5);
		sclk_out <= 1'b0;
	endtask : i2c_start

	// Stop, SDA rises while SCL high
	task automatic i2c_stop();
		wt(5);
		sda_out <= 1'b0;
		wt(5);
		sclk_out <= 1'b1;
		wt(5);
		sda_out <= 1'b1;
		wt(10);
	endtask : i2c_stop

	////////////////////////////////////////////////////////////////////////////
	// SPI: 200 ns period, well under the clock ceiling
	// Samples late in the high phase, after the device's output settles
	task automatic spi_bit(input logic b, output logic rs, output logic rp);
		sclk_out <= 1'b0;
		sda_out  <= b;
		wt(4);
		sclk_out <= 1'b1;
		wt(4);
		rs = sda_in;
		rp = strap_in;
	endtask : spi_bit

	// Command byte and one data byte; 0xFF as data releases a 3-wire line
	task automatic spi_frame(input logic mode3, input logic [7:0] cmd, input logic [7:0] d,
		output logic [7:0] rs, output logic [7:0] rp);
		logic [15:0] w;
		logic        a;
		logic        b;
		int          i;
		w = {cmd, d};
		sclk_out <= mode3;
		wt(4);
		cs_n_out <= 1'b0;
		wt(4);
		for (i = 15; i >= 0; i--) begin
			spi_bit(w[i], a, b);
			if (i < 8) begin
				rs[i] = a;
				rp[i] = b;
			end
		end
		// Mode 0 parks the clock low again
		if (!mode3) begin
			sclk_out <= 1'b0;
			wt(4);
		end
		cs_n_out <= 1'b1;
		sda_out  <= 1'b1;
		wt(8);
	endtask : spi_frame

endmodule : ahsp_host_model

// *** dv/tb_accel_host_serial_port.sv ***
// Self-checking bench of the host serial port, I2C first, then SPI.
// Assumes the port holds its register memory; SPI selection is sticky.
`timescale 1ns/1ps

module tb_accel_host_serial_port;
	import ahsp_pkg::*;

	localparam int unsigned WDT_S = 64;           // Short watchdog, cycles
	localparam int unsigned WDT_L = 256;          // Long watchdog, cycles
	localparam logic [23:0] WCFG  = 24'h000604;   // Watchdog configs per step
	localparam logic [2:0]  E100  = 3'b001;       // Released after 100 clocks
	localparam logic [2:0]  E300  = 3'b011;       // Released after 300 clocks

	logic        clk_in    = 1'b0;  // Core clock
	logic        resetn_in = 1'b0;  // Async reset, active low
	logic        strap_lvl = 1'b1;  // Strap tie level
	logic        cs_n, sclk, h_sda; // Host drive
	wire logic   sda_w, strap_w;    // Resolved wires
	logic        sda_o, sda_oe_n, sao_o, sao_oe_n, spi_mode;
	ahsp_cfg_s   cfg_o;
	int          err_count   = 0;
	int          comparisons = 0;

	always #12.5 clk_in = ~clk_in;

	// Pull-up on SDA, the tie on the strap pin when undriven
	assign sda_w   = h_sda & (sda_oe_n | sda_o);
	assign strap_w = sao_oe_n ? strap_lvl : sao_o;

	ahsp_host_model u_host (.clk_in(clk_in), .sda_in(sda_w), .strap_in(strap_w),
		.cs_n_out(cs_n), .sclk_out(sclk), .sda_out(h_sda));

	ahsp_port #(.WDT_SHORT_CYC(WDT_S), .WDT_LONG_CYC(WDT_L)) dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .cs_n_pin_in(cs_n),
		.sclk_pin_in(sclk), .sda_pin_in(sda_w), .sda_pin_out(sda_o),
		.sda_pin_oe_n_out(sda_oe_n), .slave_addr_bit_pin_in(strap_w),
		.slave_addr_bit_pin_out(sao_o), .slave_addr_bit_pin_oe_n_out(sao_oe_n),
		.spi_mode_out(spi_mode), .interface_config_out(cfg_o));

	////////////////////////////////////////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t byte %h, expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t bit %b, expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic end_sim();
		$display("Errors %0d, comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////
	// Address with write, pointer, repeated start, address with read
	task automatic i2c_pre(input logic [6:0] a, input logic [7:0] p);
		logic [8:0] r;
		u_host.i2c_start();
		u_host.i2c_byte({a, 2'b01}, r);
		chk1(r[0], 1'b0);
		u_host.i2c_byte({p, 1'b1}, r);
		chk1(r[0], 1'b0);
		u_host.i2c_start();
		u_host.i2c_byte({a, 2'b11}, r);
		chk1(r[0], 1'b0);
	endtask : i2c_pre

	// Two data bytes from pointer p upward
	task automatic i2c_wr2(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
		logic [8:0] r;
		u_host.i2c_start();
		u_host.i2c_byte({a, 2'b01}, r);
		chk1(r[0], 1'b0);
		u_host.i2c_byte({p, 1'b1}, r);
		u_host.i2c_byte({d[15:8], 1'b1}, r);
		u_host.i2c_byte({d[7:0], 1'b1}, r);
		chk1(r[0], 1'b0);
		u_host.i2c_stop();
	endtask : i2c_wr2

	// Sequential read, host ACK then NACK
	task automatic i2c_rd2(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
		logic [8:0] r;
		i2c_pre(a, p);
		u_host.i2c_byte(9'h1FE, r);
		d[15:8] = r[8:1];
		u_host.i2c_byte(9'h1FF, r);
		d[7:0] = r[8:1];
		u_host.i2c_stop();
	endtask : i2c_rd2

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [15:0] d;
		logic [8:0]  r;
		logic [7:0]  rs, rp;
		int          k;
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		wt(8);
		chk8(cfg_o, 8'h00);
		chk1(spi_mode, 1'b0);
		chk1(sda_oe_n & sao_oe_n, 1'b1);
		i2c_rd2(7'h1F, 8'h34, d);
		chk8(d[15:8], 8'h00);
		// Both strap levels, the other address refused
		for (k = 1; k >= 0; k--) begin
			strap_lvl <= k[0];
			wt(8);
			u_host.i2c_start();
			u_host.i2c_byte({(k[0] ? 7'h0F : 7'h1F), 2'b01}, r);
			chk1(r[0], 1'b1);
			u_host.i2c_stop();
			i2c_wr2(k[0] ? 7'h1F : 7'h0F, 8'h20, k[0] ? 16'hC33C : 16'h9669);
			i2c_rd2(k[0] ? 7'h1F : 7'h0F, 8'h20, d);
			chk8(d[15:8], k[0] ? 8'hC3 : 8'h96);
			chk8(d[7:0], k[0] ? 8'h3C : 8'h69);
		end
		strap_lvl <= 1'b1;
		wt(8);
		i2c_wr2(7'h1F, 8'h34, 16'h0700);
		chk8(cfg_o, 8'h07);
		// Stall mid-read with a zero bit driven: short, long, disabled
		i2c_wr2(7'h1F, 8'h10, 16'h0000);
		for (k = 0; k < 3; k++) begin
			i2c_wr2(7'h1F, 8'h34, {WCFG[k*8+:8], 8'h00});
			i2c_pre(7'h1F, 8'h10);
			wt(20);
			chk1(sda_oe_n, 1'b0);
			wt(80);
			chk1(sda_oe_n, E100[k]);
			wt(200);
			chk1(sda_oe_n, E300[k]);
			u_host.i2c_byte(9'h1FF, r);
			chk8(r[8:1], WCFG[k*8+2] ? 8'hFF : 8'h00);
			u_host.i2c_stop();
		end
		// SPI four-wire, write in one mode, read in the other
		chk1(spi_mode, 1'b0);
		for (k = 0; k < 2; k++) begin
			u_host.spi_frame(k[0], {1'b0, 7'h40 | 7'(k)}, 8'hA5 + 8'(k), rs, rp);
			chk1(spi_mode, 1'b1);
			u_host.spi_frame(!k[0], {1'b1, 7'h40 | 7'(k)}, 8'hFF, rs, rp);
			chk8(rp, 8'hA5 + 8'(k));
			chk8(rs, 8'hFF);
		end
		u_host.spi_frame(1'b0, {1'b1, 7'h20}, 8'hFF, rs, rp);
		chk8(rp, 8'h96);
		u_host.spi_frame(1'b0, {1'b0, 7'h34}, 8'h01, rs, rp);
		chk8(cfg_o, 8'h01);
		// Three-wire, data back on the shared pin, strap left alone
		for (k = 0; k < 2; k++) begin
			u_host.spi_frame(k[0], {1'b1, 7'h40 | 7'(k)}, 8'hFF, rs, rp);
			chk8(rs, 8'hA5 + 8'(k));
			chk8(rp, 8'hFF);
		end
		u_host.spi_frame(1'b1, {1'b1, 7'h34}, 8'hFF, rs, rp);
		chk8(rs, 8'h01);
		end_sim();
	end

	// Hang guard, about five and a half times the expected run
	initial begin
		repeat (60000) @(posedge clk_in);
		err_count++;
		$display("[ERR] %0t run did not finish in time", $time);
		end_sim();
	end

endmodule : tb_accel_host_serial_port
